// File: pkg/ectx_pkg.sv
package ectx_pkg;

	// ****************************************************************
	// Widths and counts
	// ****************************************************************
	localparam int BIT_W          = 3;
	localparam int TS_W           = 5;
	localparam int FRM_W          = 4;
	localparam int ADDR_W         = 4;
	localparam int REG_W          = 8;
	localparam int BIT_RATE_KHZ   = 2048;
	localparam int FRAME_TIME_US  = 125;
	localparam int MFRAME_TIME_US = 2000;
	localparam int FRAME_BITS     = FRAME_TIME_US * BIT_RATE_KHZ / 1000;
	localparam int MFRAME_BITS    = MFRAME_TIME_US * BIT_RATE_KHZ / 1000;
	localparam int NUM_TS         = FRAME_BITS / 8;
	localparam int NUM_FRM        = MFRAME_BITS / FRAME_BITS;
	localparam int LINE_LATENCY   = 5;
	localparam int SYNC_STAGES    = 2;
	localparam int DELAY_STAGES   = LINE_LATENCY - SYNC_STAGES - 1;

	// ****************************************************************
	// Frame positions
	// ****************************************************************
	localparam logic [TS_W-1:0]  TS_FRAME = 5'h00;
	localparam logic [TS_W-1:0]  TS_SIG   = 5'h10;
	localparam logic [TS_W-1:0]  LAST_TS  = TS_W'(NUM_TS - 1);
	localparam logic [BIT_W-1:0] LAST_BIT = 3'h7;
	localparam logic [FRM_W-1:0] LAST_FRM = FRM_W'(NUM_FRM - 1);
	localparam logic [FRM_W-1:0] CRC_KEEP_A  = 4'hd;
	localparam logic [FRM_W-1:0] CRC_KEEP_B  = 4'hf;
	localparam logic [FRM_W-1:0] CRC_MFA_END = 4'hc;

	// ****************************************************************
	// Codes
	// ****************************************************************
	localparam logic [7:0] IDLE_CODE = 8'hd5;
	localparam logic [6:0] FAS_CODE  = 7'h1b;
	localparam logic [5:0] CRC_MFA   = 6'h0b;

	// ****************************************************************
	// Register map, fields and reset values
	// ****************************************************************
	localparam logic [ADDR_W-1:0] ADDR_NATL   = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_EXTRA  = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_IDLE0  = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_IDLE1  = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_IDLE2  = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_IDLE3  = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h6;
	localparam logic [REG_W-1:0]  REG_RST     = 8'h00;
	localparam int INTL_POS    = 7;
	localparam int ALARM_POS   = 5;
	localparam int EXTRA_A_POS = 3;
	localparam int DMA_POS     = 2;
	localparam int EXTRA_B_POS = 1;
	localparam int EXTRA_C_POS = 0;

	// ****************************************************************
	// Pin synchroniser slots
	// ****************************************************************
	localparam int PIN_N     = 5;
	localparam int PIN_SER   = 0;
	localparam int PIN_IND   = 1;
	localparam int PIN_XTRA  = 2;
	localparam int PIN_FSYNC = 3;
	localparam int PIN_MSYNC = 4;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef struct packed {
		logic [FRM_W-1:0] frm;
		logic [TS_W-1:0]  ts;
		logic [BIT_W-1:0] bitn;
	} ectx_pos_t;

	typedef struct packed {
		logic ccs_mode;
		logic intl_from_reg;
		logic natl_from_reg;
		logic extra_from_reg;
		logic crc4_en;
		logic odd_align;
	} ectx_ctl_t;

	typedef struct packed {
		logic data;
		logic align;
		logic mframe;
	} ectx_line_t;

endpackage

// File: rtl/ectx_delay.sv
`timescale 1ns/10ps
module ectx_delay #(
	parameter int WIDTH = 3,
	parameter int DEPTH = 2
)
(
	// Clock, reset and enable.
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	// Stream in and out.
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage_r [DEPTH];

	// Fixed-length shift line; output comes from the last stage.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < DEPTH; i++)
				stage_r[i] <= '0;
		end
		else if (ce)
		begin
			stage_r[0] <= din;
			for (int i = 1; i < DEPTH; i++)
				stage_r[i] <= stage_r[i-1];
		end
	end

	assign dout = stage_r[DEPTH-1];

endmodule

// File: rtl/ectx_overhead.sv
// How it works
// - Register international bit when source bit set.
// - Otherwise international bit sampled from external input.
// - CRC4 replaces international bit except frames 13,15.
// - Register national bits when national source set.
// - Otherwise national bits sampled from external input.
// - Remote alarm drives bit 3 of non-align frames.
// - Distant alarm drives bit 6 of frame 0 slot 16.
// - Register extra bits when extra source set.
// - Otherwise extra bits sampled from external input.
// - Common channel mode passes slot 16 untouched.
// - Thirty-two idle selects force idle code.
// - Idle selects for slots 0 and 16 ignored.
// - Multiframe sync edge sets multiframe alignment.
// - Frame sync edge sets frame position.
// - Without sync edges, counters free-run and report.
// - Alignment output marks even or odd frames.
// - Serial input reaches line after five periods.
// - Frame 0 slot 16 carries zero alignment nibble.
// - Thirty-two slots of eight bits, sixteen frames.
`timescale 1ns/10ps
module ectx_overhead (
	// Clock, reset and enable.
	input  wire logic                      clk,
	input  wire logic                      resetn,
	input  wire logic                      ce,
	// Control bits from the control registers.
	input  wire ectx_pkg::ectx_ctl_t       ctl,
	// Register access port.
	input  wire logic                      reg_wr,
	input  wire logic [ectx_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [ectx_pkg::REG_W-1:0]  reg_wdata,
	output logic      [ectx_pkg::REG_W-1:0]  reg_rdata,
	// Pins from the backplane.
	input  wire logic                      transmit_serial_input,
	input  wire logic                      external_intl_national_input,
	input  wire logic                      extra_bit_input,
	input  wire logic                      frame_sync_input,
	input  wire logic                      multiframe_sync_input,
	// Checksum generator.
	input  wire logic                      crc_code_bit,
	// Line and timing outputs.
	output logic                           line_out_positive,
	output logic                           line_out_negative,
	output logic                           alignment_frame_output,
	output logic                           multiframe_output
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [ectx_pkg::PIN_N-1:0]     pin_raw;
	logic [ectx_pkg::PIN_N-1:0]     pin_s1_r;
	logic [ectx_pkg::PIN_N-1:0]     pin_s2_r;
	logic                           fs_d_r;
	logic                           ms_d_r;
	logic                           fs_edge;
	logic                           ms_edge;
	ectx_pkg::ectx_pos_t            pos_r;
	ectx_pkg::ectx_pos_t            pos_nxt;
	logic                           frame_end;
	logic                           align;
	logic [ectx_pkg::REG_W-1:0]     natl_r;
	logic [ectx_pkg::REG_W-1:0]     extra_r;
	logic [ectx_pkg::NUM_TS-1:0]    idle_r;
	logic                           intl_val;
	logic                           crc_replace;
	logic                           crc_val;
	logic                           extra_val;
	logic                           idle_hit;
	logic                           pass_data;
	logic                           mux_bit;
	ectx_pkg::ectx_line_t           line_in;
	ectx_pkg::ectx_line_t           line_dly;
	logic [2:0]                     ce_run_r;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic idle_allowed(
		input logic [ectx_pkg::TS_W-1:0] ts
	);
		idle_allowed = (ts != ectx_pkg::TS_FRAME) &&
			(ts != ectx_pkg::TS_SIG);
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	assign pin_raw = {multiframe_sync_input, frame_sync_input,
		extra_bit_input, external_intl_national_input,
		transmit_serial_input};

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
		end
		else if (ce)
		begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			fs_d_r <= 1'b0;
			ms_d_r <= 1'b0;
		end
		else if (ce)
		begin
			fs_d_r <= pin_s2_r[ectx_pkg::PIN_FSYNC];
			ms_d_r <= pin_s2_r[ectx_pkg::PIN_MSYNC];
		end
	end

	// Edges are seen on the last bit of the old frame.
	assign fs_edge = pin_s2_r[ectx_pkg::PIN_FSYNC] && !fs_d_r;
	assign ms_edge = pin_s2_r[ectx_pkg::PIN_MSYNC] && !ms_d_r;

	// ****************************************************************
	// Frame position counters
	// ****************************************************************
	assign frame_end = (pos_r.ts == ectx_pkg::LAST_TS) &&
		(pos_r.bitn == ectx_pkg::LAST_BIT);

	always_comb
	begin
		pos_nxt = pos_r;
		pos_nxt.bitn = pos_r.bitn + 3'h1;
		if (pos_r.bitn == ectx_pkg::LAST_BIT)
			pos_nxt.ts = pos_r.ts + 5'h01;
		if (frame_end)
			pos_nxt.frm = pos_r.frm + 4'h1;
		if (ms_edge)
			pos_nxt = '0;
		else if (fs_edge)
		begin
			pos_nxt.ts = '0;
			pos_nxt.bitn = '0;
		end
	end

	// Counters run free when no sync edge arrives.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			pos_r <= '0;
		else if (ce)
			pos_r <= pos_nxt;
	end

	assign align = (pos_r.frm[0] == ctl.odd_align);

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			natl_r  <= ectx_pkg::REG_RST;
			extra_r <= ectx_pkg::REG_RST;
			idle_r  <= '0;
		end
		else if (ce && reg_wr)
		begin
			unique case (reg_addr)
				ectx_pkg::ADDR_NATL:  natl_r <= reg_wdata;
				ectx_pkg::ADDR_EXTRA: extra_r <= reg_wdata;
				ectx_pkg::ADDR_IDLE0: idle_r[7:0] <= reg_wdata;
				ectx_pkg::ADDR_IDLE1: idle_r[15:8] <= reg_wdata;
				ectx_pkg::ADDR_IDLE2: idle_r[23:16] <= reg_wdata;
				ectx_pkg::ADDR_IDLE3: idle_r[31:24] <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Reserved bits read back as stored.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= ectx_pkg::REG_RST;
		else if (ce)
		begin
			unique case (reg_addr)
				ectx_pkg::ADDR_NATL:   reg_rdata <= natl_r;
				ectx_pkg::ADDR_EXTRA:  reg_rdata <= extra_r;
				ectx_pkg::ADDR_IDLE0:  reg_rdata <= idle_r[7:0];
				ectx_pkg::ADDR_IDLE1:  reg_rdata <= idle_r[15:8];
				ectx_pkg::ADDR_IDLE2:  reg_rdata <= idle_r[23:16];
				ectx_pkg::ADDR_IDLE3:  reg_rdata <= idle_r[31:24];
				ectx_pkg::ADDR_STATUS: reg_rdata <= {pos_r.frm, 3'h0, align};
				default:               reg_rdata <= ectx_pkg::REG_RST;
			endcase
		end
	end

	// ****************************************************************
	// Overhead insertion
	// ****************************************************************
	always_comb
	begin
		intl_val = ctl.intl_from_reg ? natl_r[ectx_pkg::INTL_POS] :
			pin_s2_r[ectx_pkg::PIN_IND];
		crc_replace = ctl.crc4_en && (pos_r.frm != ectx_pkg::CRC_KEEP_A) &&
			(pos_r.frm != ectx_pkg::CRC_KEEP_B);
		crc_val = crc_code_bit;
		if (!align && (pos_r.frm < ectx_pkg::CRC_MFA_END))
			crc_val = ectx_pkg::CRC_MFA[3'h5 - pos_r.frm[3:1]];
		extra_val = pin_s2_r[ectx_pkg::PIN_XTRA];
		if (ctl.extra_from_reg)
		begin
			unique case (pos_r.bitn)
				3'h4: extra_val = extra_r[ectx_pkg::EXTRA_A_POS];
				3'h6: extra_val = extra_r[ectx_pkg::EXTRA_B_POS];
				default: extra_val = extra_r[ectx_pkg::EXTRA_C_POS];
			endcase
		end
		idle_hit = idle_r[pos_r.ts] && idle_allowed(pos_r.ts);
		pass_data = 1'b0;
		mux_bit = pin_s2_r[ectx_pkg::PIN_SER];
		if (pos_r.ts == ectx_pkg::TS_FRAME)
		begin
			if (pos_r.bitn == 3'h0)
				mux_bit = crc_replace ? crc_val : intl_val;
			else if (align)
				mux_bit = ectx_pkg::FAS_CODE[3'h7 - pos_r.bitn];
			else if (pos_r.bitn == 3'h1)
				mux_bit = 1'b1;
			else if (pos_r.bitn == 3'h2)
				mux_bit = natl_r[ectx_pkg::ALARM_POS];
			else if (ctl.natl_from_reg)
				mux_bit = natl_r[3'h7 - pos_r.bitn];
			else
				mux_bit = pin_s2_r[ectx_pkg::PIN_IND];
		end
		else if ((pos_r.ts == ectx_pkg::TS_SIG) && (pos_r.frm == '0) &&
			!ctl.ccs_mode)
		begin
			if (pos_r.bitn < 3'h4)
				mux_bit = 1'b0;
			else if (pos_r.bitn == 3'h5)
				mux_bit = extra_r[ectx_pkg::DMA_POS];
			else
				mux_bit = extra_val;
		end
		else if (idle_hit)
			mux_bit = ectx_pkg::IDLE_CODE[3'h7 - pos_r.bitn];
		else
			pass_data = 1'b1;
	end

	// ****************************************************************
	// Line pipeline
	// ****************************************************************
	assign line_in = '{data: mux_bit, align: align,
		mframe: (pos_r.frm == '0)};

	ectx_delay #(
		.WIDTH ($bits(ectx_pkg::ectx_line_t)),
		.DEPTH (ectx_pkg::DELAY_STAGES)
	) u_delay (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.din    (line_in),
		.dout   (line_dly)
	);

	// Output stage completes the five-period path.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			line_out_positive      <= 1'b0;
			line_out_negative      <= 1'b0;
			alignment_frame_output <= 1'b0;
			multiframe_output      <= 1'b0;
		end
		else if (ce)
		begin
			line_out_positive      <= line_dly.data;
			line_out_negative      <= 1'b0;
			alignment_frame_output <= line_dly.align;
			multiframe_output      <= line_dly.mframe;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			ce_run_r <= 3'h0;
		else if (!ce)
			ce_run_r <= 3'h0;
		else if (ce_run_r != 3'h7)
			ce_run_r <= ce_run_r + 3'h1;
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	a_line_delay: assert property (
		(ce_run_r == 3'h7 && $past(pass_data, 3)) |->
		line_out_positive == $past(transmit_serial_input, 5)
	) else $error("Serial data not delayed five periods.");

	a_idle_fill: assert property (
		(ce_run_r == 3'h7 && $past(idle_hit, 3)) |->
		line_out_positive ==
		$past(ectx_pkg::IDLE_CODE[3'h7 - pos_r.bitn], 3)
	) else $error("Idle code not sent.");

	a_idle_skip: assert property (
		(pos_r.ts == ectx_pkg::TS_SIG &&
		(ctl.ccs_mode || pos_r.frm != '0)) |->
		mux_bit == pin_s2_r[ectx_pkg::PIN_SER]
	) else $error("Idle applied to slot 16.");

	a_remote_alarm: assert property (
		(pos_r.ts == '0 && !align && pos_r.bitn == 3'h2) |->
		mux_bit == natl_r[ectx_pkg::ALARM_POS]
	) else $error("Remote alarm bit wrong.");

	a_mfa_nibble: assert property (
		(pos_r.ts == ectx_pkg::TS_SIG && pos_r.frm == '0 &&
		!ctl.ccs_mode && pos_r.bitn < 3'h4) |-> !mux_bit
	) else $error("Multiframe nibble not zero.");

	a_distant_alarm: assert property (
		(pos_r.ts == ectx_pkg::TS_SIG && pos_r.frm == '0 &&
		!ctl.ccs_mode && pos_r.bitn == 3'h5) |->
		mux_bit == extra_r[ectx_pkg::DMA_POS]
	) else $error("Distant alarm bit wrong.");

	a_ccs_pass: assert property (
		(ctl.ccs_mode && pos_r.ts == ectx_pkg::TS_SIG) |->
		mux_bit == pin_s2_r[ectx_pkg::PIN_SER]
	) else $error("Slot 16 altered in common channel mode.");

	a_intl_source: assert property (
		(pos_r.ts == '0 && pos_r.bitn == '0 && !crc_replace &&
		ctl.intl_from_reg) |-> mux_bit == natl_r[ectx_pkg::INTL_POS]
	) else $error("International bit not from register.");

	a_crc_keep: assert property (
		(pos_r.ts == '0 && pos_r.bitn == '0 &&
		pos_r.frm == ectx_pkg::CRC_KEEP_A) |-> mux_bit == intl_val
	) else $error("Frame 13 international bit replaced.");

	a_frame_sync: assert property (
		(ce && fs_edge) |=> (pos_r.ts == '0 && pos_r.bitn == '0)
	) else $error("Frame sync did not align.");

	a_mframe_sync: assert property (
		(ce && ms_edge) |=> (pos_r == '0)
	) else $error("Multiframe sync did not align.");

	a_free_run: assert property (
		(ce && !fs_edge && !ms_edge && frame_end) |=>
		(pos_r.frm == $past(pos_r.frm) + 4'h1 && pos_r.ts == '0)
	) else $error("Counters did not wrap.");

	a_align_toggle: assert property (
		(ce && frame_end && !ms_edge && $stable(ctl)) |=>
		align != ($past(align) ^ $changed(ctl.odd_align))
	) else $error("Alignment frame did not alternate.");

	c_frame_sync: cover property (ce && fs_edge);
	c_mframe_sync: cover property (ce && ms_edge);
	c_idle_used: cover property (ce && idle_hit);

endmodule

// File: sim/ectx_backplane.sv
`timescale 1ns/10ps
module ectx_backplane (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic resetn,
	// Sync enable from the bench.
	input  wire logic go,
	// Backplane pins.
	output logic      ser,
	output logic      ind,
	output logic      xtr,
	output logic      fsync,
	output logic      msync
);
	// ****************************************************************
	// Random pin data and sync pulses at frame and multiframe multiples
	// ****************************************************************
	logic [7:0] lfsr_r;
	int         cnt_r;

	always @(negedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lfsr_r <= 8'h60;
			cnt_r <= 0;
			ser <= 1'b0;
			ind <= 1'b0;
			xtr <= 1'b0;
			fsync <= 1'b0;
			msync <= 1'b0;
		end
		else
		begin
			lfsr_r <= {lfsr_r[6:0],
				lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
			ser <= lfsr_r[0];
			ind <= lfsr_r[3];
			xtr <= lfsr_r[6];
			cnt_r <= go ? cnt_r + 1 : cnt_r;
			fsync <= go && (cnt_r % 512) < 3;
			msync <= go && (cnt_r % 8192) < 3;
		end
	end
endmodule

// File: sim/ectx_overhead_tb.sv
`timescale 1ns/10ps
module ectx_overhead_tb;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic                        clk;
	logic                        resetn;
	logic                        ce;
	ectx_pkg::ectx_ctl_t         ctl;
	logic                        reg_wr;
	logic [ectx_pkg::ADDR_W-1:0] reg_addr;
	logic [ectx_pkg::REG_W-1:0]  reg_wdata;
	logic [ectx_pkg::REG_W-1:0]  reg_rdata;
	logic                        ser;
	logic                        ind;
	logic                        xtr;
	logic                        fsync;
	logic                        msync;
	logic                        crc_bit;
	logic                        lpos;
	logic                        lneg;
	logic                        align_o;
	logic                        mf_o;
	logic                        go;
	logic                        chk_en;
	int                          n_errors;
	int                          n_compared;
	int                          cyc;
	int                          s0;
	logic [7:0]                  lfsr_r;
	logic [2:0]                  hist [0:8191];
	logic [7:0]                  shadow [0:5];
	logic [5:0]                  tbl [0:4] =
		'{6'h1c, 6'h02, 6'h35, 6'h1e, 6'h01};

	ectx_backplane PARTNER (.clk(clk), .resetn(resetn), .go(go), .ser(ser),
		.ind(ind), .xtr(xtr), .fsync(fsync), .msync(msync));

	ectx_overhead DUT (.clk(clk), .resetn(resetn), .ce(ce), .ctl(ctl),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .transmit_serial_input(ser),
		.external_intl_national_input(ind), .extra_bit_input(xtr),
		.frame_sync_input(fsync), .multiframe_sync_input(msync),
		.crc_code_bit(crc_bit), .line_out_positive(lpos),
		.line_out_negative(lneg), .alignment_frame_output(align_o),
		.multiframe_output(mf_o));

	always #25 clk = ~clk;

	// ****************************************************************
	// Model, compare and bus tasks
	// ****************************************************************
	function automatic logic [7:0] lfsr_next(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	function automatic logic exp_bit(input int f, input int s, input int b,
		input logic [2:0] h);
		logic        al;
		logic [7:0]  nb;
		logic [7:0]  xb;
		logic [31:0] idl;
		al = (f % 2) == ctl.odd_align;
		nb = shadow[0];
		xb = shadow[1];
		idl = {shadow[5], shadow[4], shadow[3], shadow[2]};
		if (s == 0 && b == 0 && ctl.crc4_en && f != 13 && f != 15)
			return al ? crc_bit : ectx_pkg::CRC_MFA[5 - f / 2];
		if (s == 0 && b == 0)
			return ctl.intl_from_reg ? nb[7] : h[1];
		if (s == 0 && al)
			return ectx_pkg::FAS_CODE[7 - b];
		if (s == 0 && b == 1)
			return 1'b1;
		if (s == 0 && b == 2)
			return nb[5];
		if (s == 0)
			return ctl.natl_from_reg ? nb[7 - b] : h[1];
		if (s == 16 && f == 0 && !ctl.ccs_mode && b < 4)
			return 1'b0;
		if (s == 16 && f == 0 && !ctl.ccs_mode && b == 5)
			return xb[2];
		if (s == 16 && f == 0 && !ctl.ccs_mode)
			return ctl.extra_from_reg ? xb[7 - b] : h[0];
		if (idl[s] && s != 16)
			return ectx_pkg::IDLE_CODE[7 - b];
		return h[2];
	endfunction

	task automatic check(input logic [7:0] got, input logic [7:0] want,
		input string msg);
		n_compared++;
		if (got !== want)
		begin
			n_errors++;
			$display("wrong value at %0t ns: %s", $time, msg);
		end
	endtask

	task automatic check_line(input int k);
		int         p;
		logic [7:0] want;
		p = (k - s0 - 6) % 4096;
		want[7:4] = 4'h0;
		want[3] = exp_bit(p / 256, (p / 8) % 32, p % 8, hist[(k - 5) % 8192]);
		want[2] = 1'b0;
		want[1] = ((p / 256) % 2) == ctl.odd_align;
		want[0] = p < 256;
		check({4'h0, lpos, lneg, align_o, mf_o}, want, "line");
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask

	task automatic reg_check(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk);
		reg_addr = a;
		repeat (2) @(negedge clk);
		check(reg_rdata, e, "register read");
	endtask

	task automatic load_regs(input int ph);
		logic [7:0] v;
		for (int a = 0; a < 6; a++)
		begin
			lfsr_r = lfsr_next(lfsr_r);
			v = (ph == 2 && a > 1) ? 8'hff : lfsr_r;
			if (a == 0)
				v = v & 8'hbf;
			if (a == 1)
				v = v & 8'h0f;
			shadow[a] = v;
			reg_write(4'(a), v);
		end
		for (int a = 0; a < 6; a++)
			reg_check(4'(a), shadow[a]);
	endtask

	task automatic close_out();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	always @(posedge clk)
	begin
		hist[cyc % 8192] = {ser, ind, xtr};
		if (msync === 1'b1 && s0 < 0)
			s0 = cyc;
		cyc++;
	end

	always @(negedge clk)
	begin
		if (chk_en === 1'b1 && s0 >= 0 && cyc - s0 >= 6)
			check_line(cyc);
	end

	initial
	begin
		#(30000 * 50);
		n_errors++;
		$display("wrong value at %0t ns: watchdog expired", $time);
		close_out();
	end

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		ce = 1'b1;
		ctl = '0;
		reg_wr = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		crc_bit = 1'b0;
		go = 1'b0;
		chk_en = 1'b0;
		n_errors = 0;
		n_compared = 0;
		cyc = 0;
		s0 = -1;
		lfsr_r = 8'h60;
		repeat (4) @(negedge clk);
		resetn = 1'b1;
		for (int a = 0; a < 6; a++)
			reg_check(4'(a), 8'h00);
		reg_check(4'h7, 8'h00);
		reg_write(4'h9, 8'hff);
		reg_check(4'h9, 8'h00);
		for (int ph = 0; ph < 5; ph++)
		begin
			chk_en = 1'b0;
			go = ph < 3;
			ctl = ectx_pkg::ectx_ctl_t'(tbl[ph]);
			crc_bit = ~ph[1];
			load_regs(ph);
			repeat (12) @(negedge clk);
			chk_en = 1'b1;
			repeat (4200) @(negedge clk);
		end
		close_out();
	end
endmodule
